// >>> boot_seq_pkg.sv
// Shared constants for the reset and boot sequencer and its host/test controller
package boot_seq_pkg;
   // Boot mode strap encodings
   localparam logic [1:0] BOOT_NONE = 2'h0;
   localparam logic [1:0] BOOT_HOST = 2'h1;
   localparam logic [1:0] BOOT_ROM = 2'h2;
   // Boot image geometry
   localparam int ROM_BYTES = 1024;
   localparam int WORD_BYTES = 4;
   localparam int ROM_WORDS = ROM_BYTES / WORD_BYTES;
   localparam logic [8:0] ROM_LAST_IDX = 9'(ROM_WORDS - 1);
   localparam logic [8:0] ROM_WORDS_9 = 9'(ROM_WORDS);
   localparam logic [31:0] ROM_BASE = 32'h1000_0000;
   localparam logic [31:0] CPU_START_ADDR = 32'h0000_0000;
   // Host port addressing: bit 8 selects the host port control register
   localparam int HP_ADDR_W = 9;
   localparam int HP_CTL_SEL = 8;
   localparam int HPC_INT_BIT = 0;
   // Emulation config pin code that selects boundary scan
   localparam logic [1:0] EMU_BSCAN = 2'h0;
   // Controller register offsets (AXI4-Lite byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_CMD = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RDATA = 8'h14;
   // Control register fields and reset value
   localparam int CTRL_TRST_HIGH = 0;
   localparam int CTRL_TRST_FLOAT = 1;
   localparam int CTRL_EMU_LO = 2;
   localparam int CTRL_USE_PCI = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam int CMD_GO = 0;
   localparam int CMD_WRITE = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> boot_link_if.sv
// Link between the sequencer (device end) and its host / test controller end
`timescale 1ns/1ps
interface boot_link_if;
   logic hpReq;
   logic pciReq;
   logic hpWrite;
   logic [boot_seq_pkg::HP_ADDR_W-1:0] hpAddr;
   logic [31:0] hpWdata;
   logic [31:0] hpRdata;
   logic hpAck;
   logic trstOut;
   logic trstOeN;
   logic [1:0] emuCfg;
   logic trstN;

   // Undriven test reset reads as asserted
   assign trstN = trstOeN ? 1'b0 : trstOut;

   modport dev (
      input hpReq, pciReq, hpWrite, hpAddr, hpWdata, trstN, emuCfg,
      output hpAck, hpRdata
   );
   modport hst (
      output hpReq, pciReq, hpWrite, hpAddr, hpWdata, trstOut, trstOeN, emuCfg,
      input hpAck, hpRdata
   );
endinterface

// >>> boot_dev_end.sv
// Device end: reset, boot mode sequencing, host-boot memory and emulation pin latch
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps

module boot_dev_end (
   input wire logic clk,
   input wire logic rst_n,
   boot_link_if.dev link,
   input wire logic [1:0] bootStrap,
   input wire logic pciBootSel,
   input wire logic sdramUsed,
   input wire logic sdramInitDone,
   input wire logic [31:0] romData,
   input wire logic cpuClrHostInt,
   input wire logic [7:0] cpuRdIdx,
   output logic romRd,
   output logic [31:0] romAddr,
   output logic cpuStall,
   output logic [31:0] cpuStartAddr,
   output logic cpuHostInt,
   output logic [31:0] cpuRdData,
   output logic [1:0] bootModeLatched,
   output logic pciSelLatched,
   output logic emuMode,
   output logic emuValid
);
   typedef enum logic [2:0] {ST_SAMPLE, ST_HOST_WAIT, ST_ROM_COPY, ST_SDRAM_WAIT, ST_RUN} state_t;

   state_t state_r;
   state_t state_nxt;
   logic [31:0] mem_r [boot_seq_pkg::ROM_WORDS];
   logic [1:0] bootMode_r;
   logic pciSel_r;
   logic hostIntBit_r;
   logic hpAck_r;
   logic [31:0] hpRdata_r;
   logic cpuStall_r;
   logic cpuHostInt_r;
   logic [31:0] cpuRdData_r;
   logic [8:0] romIdx_r;
   logic [7:0] romWrIdx_r;
   logic romPend_r;
   logic romTake_r;
   logic [7:0] romTakeIdx_r;
   logic romRd_r;
   logic [31:0] romAddr_r;
   logic trstPrev_r;
   logic emuMode_r;
   logic emuValid_r;

   ////////////////////////////////////////////////////////////////////////////
   // Host port decode
   wire logic portReq = pciSel_r ? link.pciReq : link.hpReq;
   // Host port is closed while the straps are sampled and while the block copy owns the memory
   wire logic hostAcc = portReq && !hpAck_r && state_r != ST_SAMPLE && state_r != ST_ROM_COPY;
   wire logic ctlAcc = hostAcc && link.hpAddr[boot_seq_pkg::HP_CTL_SEL];
   wire logic memWr = hostAcc && !link.hpAddr[boot_seq_pkg::HP_CTL_SEL] && link.hpWrite;
   wire logic [7:0] hpIdx = link.hpAddr[7:0];
   // A set while the bit is still high is dropped
   wire logic setInt = ctlAcc && link.hpWrite && link.hpWdata[boot_seq_pkg::HPC_INT_BIT] && !hostIntBit_r;
   wire logic releaseHost = setInt && state_r == ST_HOST_WAIT;
   wire logic clrInt = cpuClrHostInt && state_r == ST_RUN;
   wire logic romIssue = state_r == ST_ROM_COPY && romIdx_r < boot_seq_pkg::ROM_WORDS_9;
   wire logic romDone = romTake_r && romTakeIdx_r == boot_seq_pkg::ROM_LAST_IDX[7:0];
   wire logic trstRise = link.trstN && !trstPrev_r;

   ////////////////////////////////////////////////////////////////////////////
   // Boot sequence
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_SAMPLE: begin
            if (bootStrap == boot_seq_pkg::BOOT_HOST) begin
               state_nxt = ST_HOST_WAIT;
            end else if (bootStrap == boot_seq_pkg::BOOT_ROM) begin
               state_nxt = ST_ROM_COPY;
            end else begin
               state_nxt = ST_SDRAM_WAIT;
            end
         end
         ST_HOST_WAIT: begin
            if (releaseHost) begin
               state_nxt = ST_RUN;
            end
         end
         ST_ROM_COPY: begin
            if (romDone) begin
               state_nxt = ST_RUN;
            end
         end
         ST_SDRAM_WAIT: begin
            if (!sdramUsed || sdramInitDone) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            state_nxt = ST_RUN;
         end
         default: begin
            state_nxt = ST_SAMPLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_SAMPLE;
         cpuStall_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cpuStall_r <= state_nxt != ST_RUN;
      end
   end

   // Straps taken once, on the first edge after release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bootMode_r <= boot_seq_pkg::BOOT_NONE;
         pciSel_r <= 1'b0;
      end else if (state_r == ST_SAMPLE) begin
         bootMode_r <= bootStrap;
         pciSel_r <= pciBootSel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Host-to-CPU interrupt bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hostIntBit_r <= 1'b0;
         cpuHostInt_r <= 1'b0;
      end else begin
         if (setInt) begin
            hostIntBit_r <= 1'b1;
         end else if (clrInt) begin
            hostIntBit_r <= 1'b0;
         end
         // Stalled CPU never sees the boot release as an interrupt
         cpuHostInt_r <= setInt && state_r == ST_RUN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Host port answer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hpAck_r <= 1'b0;
         hpRdata_r <= 32'h0000_0000;
      end else begin
         hpAck_r <= hostAcc;
         if (ctlAcc) begin
            hpRdata_r <= {31'h0000_0000, hostIntBit_r};
         end else if (hostAcc) begin
            hpRdata_r <= mem_r[hpIdx];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ROM block copy, one word per cycle; the word answers one cycle after its address stands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         romIdx_r <= 9'h000;
         romWrIdx_r <= 8'h00;
         romPend_r <= 1'b0;
         romTake_r <= 1'b0;
         romTakeIdx_r <= 8'h00;
         romRd_r <= 1'b0;
         romAddr_r <= boot_seq_pkg::ROM_BASE;
      end else begin
         romRd_r <= romIssue;
         romPend_r <= romIssue;
         romTake_r <= romPend_r;
         romTakeIdx_r <= romWrIdx_r;
         if (romIssue) begin
            romAddr_r <= boot_seq_pkg::ROM_BASE + {21'h00_0000, romIdx_r, 2'h0};
            romWrIdx_r <= romIdx_r[7:0];
            romIdx_r <= romIdx_r + 9'h001;
         end
      end
   end

   // Boot memory at address zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < boot_seq_pkg::ROM_WORDS; i++) begin
            mem_r[i] <= 32'h0000_0000;
         end
         cpuRdData_r <= 32'h0000_0000;
      end else begin
         if (romTake_r) begin
            mem_r[romTakeIdx_r] <= romData;
         end else if (memWr) begin
            mem_r[hpIdx] <= link.hpWdata;
         end
         cpuRdData_r <= mem_r[cpuRdIdx];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Emulation logic: held clear by test reset and by rst_n; the boot sequence never touches it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trstPrev_r <= 1'b1;
         emuMode_r <= 1'b0;
         emuValid_r <= 1'b0;
      end else begin
         trstPrev_r <= link.trstN;
         if (!link.trstN) begin
            emuMode_r <= 1'b0;
            emuValid_r <= 1'b0;
         end else if (trstRise) begin
            emuMode_r <= link.emuCfg != boot_seq_pkg::EMU_BSCAN;
            emuValid_r <= 1'b1;
         end
      end
   end

   assign link.hpAck = hpAck_r;
   assign link.hpRdata = hpRdata_r;
   assign romRd = romRd_r;
   assign romAddr = romAddr_r;
   assign cpuStall = cpuStall_r;
   assign cpuStartAddr = boot_seq_pkg::CPU_START_ADDR;
   assign cpuHostInt = cpuHostInt_r;
   assign cpuRdData = cpuRdData_r;
   assign bootModeLatched = bootMode_r;
   assign pciSelLatched = pciSel_r;
   assign emuMode = emuMode_r;
   assign emuValid = emuValid_r;
endmodule

// >>> boot_host_end.sv
// Host and test controller end: AXI4-Lite register slave driving the boot link
`timescale 1ns/1ps
module boot_host_end (
   input wire logic clk,
   input wire logic rst_n,
   boot_link_if.hst link,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   logic awready_r, wready_r, awHave_r, wHave_r, bvalid_r, arready_r, rvalid_r, busy_r;
   logic reqHp_r, reqPci_r, wrOp_r;
   logic [7:0] awAddr_r;
   logic [31:0] wData_r, rdata_r, hpWdata_r, hpRdata_r;
   logic [3:0] wStrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [4:0] ctrl_r;
   logic [8:0] hpAddr_r;

   function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Write decode
   wire logic doWrite = awHave_r && wHave_r && !bvalid_r;
   wire logic [31:0] merged = mergeStrb(32'h0000_0000, wData_r, wStrb_r);
   wire logic wCtrl = awAddr_r == boot_seq_pkg::REG_CTRL;
   wire logic wAddr = awAddr_r == boot_seq_pkg::REG_ADDR;
   wire logic wWdat = awAddr_r == boot_seq_pkg::REG_WDATA;
   wire logic wCmd = awAddr_r == boot_seq_pkg::REG_CMD;
   wire logic wMapped = wCtrl || wAddr || wWdat || wCmd || awAddr_r == boot_seq_pkg::REG_STATUS;
   // Go while a transfer is open is ignored
   wire logic start = doWrite && wCmd && merged[boot_seq_pkg::CMD_GO] && !busy_r;
   wire logic [31:0] ctrlMerged = mergeStrb({27'h000_0000, ctrl_r}, wData_r, wStrb_r);
   wire logic [31:0] addrMerged = mergeStrb({23'h00_0000, hpAddr_r}, wData_r, wStrb_r);

   // Read decode; all six registers answer OKAY (command reads zero), other offsets error
   wire logic arTake = arvalid && arready_r;
   wire logic rMapped = araddr == boot_seq_pkg::REG_CTRL || araddr == boot_seq_pkg::REG_ADDR ||
      araddr == boot_seq_pkg::REG_WDATA || araddr == boot_seq_pkg::REG_CMD ||
      araddr == boot_seq_pkg::REG_STATUS || araddr == boot_seq_pkg::REG_RDATA;
   wire logic [31:0] rMux = araddr == boot_seq_pkg::REG_CTRL ? {27'h000_0000, ctrl_r} :
      araddr == boot_seq_pkg::REG_ADDR ? {23'h00_0000, hpAddr_r} :
      araddr == boot_seq_pkg::REG_WDATA ? hpWdata_r :
      araddr == boot_seq_pkg::REG_STATUS ? {31'h0000_0000, busy_r} :
      araddr == boot_seq_pkg::REG_RDATA ? hpRdata_r : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channels, address and data taken in either order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         awHave_r <= 1'b0;
         wHave_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= boot_seq_pkg::RESP_OKAY;
         awAddr_r <= 8'h00;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
      end else begin
         awready_r <= awvalid && !awready_r && !awHave_r && !bvalid_r;
         wready_r <= wvalid && !wready_r && !wHave_r && !bvalid_r;
         if (awvalid && awready_r) begin
            awHave_r <= 1'b1;
            awAddr_r <= awaddr;
         end
         if (wvalid && wready_r) begin
            wHave_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
         if (doWrite) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wMapped ? boot_seq_pkg::RESP_OKAY : boot_seq_pkg::RESP_SLVERR;
         end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= boot_seq_pkg::RESP_OKAY;
      end else begin
         arready_r <= arvalid && !arready_r && !rvalid_r;
         if (arTake) begin
            rvalid_r <= 1'b1;
            rdata_r <= rMux;
            rresp_r <= rMapped ? boot_seq_pkg::RESP_OKAY : boot_seq_pkg::RESP_SLVERR;
         end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and link transfer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= boot_seq_pkg::CTRL_RST;
         hpAddr_r <= 9'h000;
         hpWdata_r <= 32'h0000_0000;
         hpRdata_r <= 32'h0000_0000;
         busy_r <= 1'b0;
         reqHp_r <= 1'b0;
         reqPci_r <= 1'b0;
         wrOp_r <= 1'b0;
      end else begin
         if (doWrite && wCtrl) begin
            ctrl_r <= ctrlMerged[4:0];
         end
         if (doWrite && wAddr) begin
            hpAddr_r <= addrMerged[8:0];
         end
         if (doWrite && wWdat) begin
            hpWdata_r <= mergeStrb(hpWdata_r, wData_r, wStrb_r);
         end
         if (start) begin
            busy_r <= 1'b1;
            wrOp_r <= merged[boot_seq_pkg::CMD_WRITE];
            reqHp_r <= !ctrl_r[boot_seq_pkg::CTRL_USE_PCI];
            reqPci_r <= ctrl_r[boot_seq_pkg::CTRL_USE_PCI];
         end else if (busy_r && link.hpAck) begin
            busy_r <= 1'b0;
            reqHp_r <= 1'b0;
            reqPci_r <= 1'b0;
            hpRdata_r <= link.hpRdata;
         end
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign link.hpReq = reqHp_r;
   assign link.pciReq = reqPci_r;
   assign link.hpWrite = wrOp_r;
   assign link.hpAddr = hpAddr_r;
   assign link.hpWdata = hpWdata_r;
   assign link.trstOut = ctrl_r[boot_seq_pkg::CTRL_TRST_HIGH];
   assign link.trstOeN = ctrl_r[boot_seq_pkg::CTRL_TRST_FLOAT];
   assign link.emuCfg = ctrl_r[boot_seq_pkg::CTRL_EMU_LO +: 2];
endmodule

// >>> dsp_reset_boot_sequencer_assertions.sv
// Concurrent checks on the boot link and the device end's sequencing outputs
`timescale 1ns/1ps
module dsp_reset_boot_sequencer_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hpReq,
   input wire logic pciReq,
   input wire logic hpAck,
   input wire logic trstOeN,
   input wire logic trstN,
   input wire logic [1:0] emuCfg,
   input wire logic cpuStall,
   input wire logic cpuHostInt,
   input wire logic [1:0] bootModeLatched,
   input wire logic pciSelLatched,
   input wire logic emuMode,
   input wire logic emuValid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [1:0] runCnt_r;

   // Straps are latched on the first edge, so stability is judged from the fourth on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) runCnt_r <= 2'h0;
      else if (runCnt_r != 2'h3) runCnt_r <= runCnt_r + 2'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   chk_ack_pulse: assert property (hpAck |=> !hpAck)
      else $error("host port ack longer than one cycle");
   chk_ack_line: assert property (hpAck |-> $past(pciSelLatched ? pciReq : hpReq))
      else $error("ack without request on the selected line");
   chk_trst_pull: assert property (trstOeN |-> !trstN)
      else $error("undriven test reset not read low");
   chk_emu_latch: assert property ($rose(trstN) |-> ##[1:2] (emuValid && emuMode == (emuCfg != boot_seq_pkg::EMU_BSCAN)))
      else $error("emulation pins not latched on test reset rise");
   chk_emu_clear: assert property (!trstN [*2] |-> !emuValid)
      else $error("emulation state kept while test reset low");
   chk_int_running: assert property (cpuHostInt |-> !cpuStall)
      else $error("host interrupt delivered to stalled cpu");
   chk_host_release: assert property ($fell(cpuStall) && bootModeLatched == boot_seq_pkg::BOOT_HOST |-> hpAck)
      else $error("host boot stall released without host write");
   chk_straps_held: assert property (runCnt_r == 2'h3 |-> $stable(bootModeLatched) && $stable(pciSelLatched))
      else $error("latched straps changed while running");

   cover property ($fell(cpuStall));
   cover property (cpuHostInt);
   cover property ($rose(emuValid));
endmodule

// >>> test_dsp_reset_boot_sequencer.sv
// Self-checking bench for both ends of the reset and boot sequencer
`timescale 1ns/1ps
module test_dsp_reset_boot_sequencer;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] bootStrap = 2'h0;
   logic pciBootSel = 1'b0;
   logic sdramUsed = 1'b0;
   logic sdramInitDone = 1'b0;
   logic cpuClrHostInt = 1'b0;
   logic [31:0] romData = 32'h0;
   logic [7:0] cpuRdIdx = 8'h0;
   logic romRd, cpuStall, cpuHostInt, pciSelLatched, emuMode, emuValid;
   logic [31:0] romAddr, cpuStartAddr, cpuRdData;
   logic [1:0] bootModeLatched;
   logic [7:0] awaddr = 8'h0;
   logic [7:0] araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, q, d;
   logic [1:0] r;
   logic [1:0] ok = boot_seq_pkg::RESP_OKAY;
   logic [7:0] ix;
   logic [31:0] mem[int];
   int errors = 0;
   int n_checks = 0;
   int seed = 33;
   int romCnt = 0;
   int intCnt = 0;

   boot_link_if link();
   boot_dev_end i_boot_dev_end (.clk(clk), .rst_n(rst_n), .link(link), .bootStrap(bootStrap),
      .pciBootSel(pciBootSel), .sdramUsed(sdramUsed), .sdramInitDone(sdramInitDone), .romData(romData),
      .cpuClrHostInt(cpuClrHostInt), .cpuRdIdx(cpuRdIdx), .romRd(romRd), .romAddr(romAddr), .cpuStall(cpuStall),
      .cpuStartAddr(cpuStartAddr), .cpuHostInt(cpuHostInt), .cpuRdData(cpuRdData),
      .bootModeLatched(bootModeLatched), .pciSelLatched(pciSelLatched), .emuMode(emuMode), .emuValid(emuValid));
   boot_host_end i_boot_host_end (.clk(clk), .rst_n(rst_n), .link(link), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));
   dsp_reset_boot_sequencer_assertions i_dsp_reset_boot_sequencer_assertions (.clk(clk), .rst_n(rst_n),
      .hpReq(link.hpReq), .pciReq(link.pciReq), .hpAck(link.hpAck), .trstOeN(link.trstOeN), .trstN(link.trstN),
      .emuCfg(link.emuCfg), .cpuStall(cpuStall), .cpuHostInt(cpuHostInt), .bootModeLatched(bootModeLatched),
      .pciSelLatched(pciSelLatched), .emuMode(emuMode), .emuValid(emuValid));

   initial forever #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic axiWr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(er));
   endtask

   task automatic axiRd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      v = rdata;
      rr = rresp;
   endtask

   // One host port access through the controller, waiting out its busy flag
   task automatic linkOp(input logic wr, input logic [8:0] a, input logic [31:0] v, output logic [31:0] o);
      logic [1:0] rr;
      axiWr(boot_seq_pkg::REG_ADDR, 32'(a), ok);
      axiWr(boot_seq_pkg::REG_WDATA, v, ok);
      axiWr(boot_seq_pkg::REG_CMD, {30'h0, wr, 1'b1}, ok);
      do axiRd(boot_seq_pkg::REG_STATUS, o, rr); while (o[0] !== 1'b0);
      axiRd(boot_seq_pkg::REG_RDATA, o, rr);
   endtask

   task automatic doReset(input logic [1:0] s, input logic p, input logic su);
      @(posedge clk);
      rst_n <= 1'b0;
      bootStrap <= s;
      pciBootSel <= p;
      sdramUsed <= su;
      sdramInitDone <= 1'b0;
      repeat (20) @(posedge clk);
      chk("rstStall", 32'(cpuStall), 32'h1);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      // Straps wander after release; the latched copy must not follow
      bootStrap <= 2'($random(seed));
      pciBootSel <= 1'($random(seed));
      @(posedge clk);
      chk("mode", 32'(bootModeLatched), 32'(s));
      chk("pciSel", 32'(pciSelLatched), 32'(p));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // ROM image: fixed one-cycle latency
   always @(posedge clk) begin
      if (cpuHostInt === 1'b1) intCnt++;
      if (romRd === 1'b1) begin
         chk("romAddr", romAddr, boot_seq_pkg::ROM_BASE + 32'(4 * romCnt));
         romCnt++;
      end
      romData <= romAddr ^ 32'h5A5A_0000;
   end

   initial begin
      repeat (50000) @(posedge clk);
      errors++;
      end_of_test();
   end

   initial begin
      doReset(boot_seq_pkg::BOOT_NONE, 1'b0, 1'b0);
      axiRd(boot_seq_pkg::REG_CTRL, q, r);
      chk("ctrlRst", q, 32'(boot_seq_pkg::CTRL_RST));
      axiWr(8'h3C, 32'h1, boot_seq_pkg::RESP_SLVERR);
      axiRd(8'h3C, q, r);
      chk("unmapped", {q[29:0], r}, 32'(boot_seq_pkg::RESP_SLVERR));
      for (int p = 0; p < 2; p++) begin
         doReset(boot_seq_pkg::BOOT_HOST, 1'(p), 1'b0);
         axiWr(boot_seq_pkg::REG_CTRL, 32'h1 | 32'(p << 4), ok);
         mem.delete();
         for (int k = 0; k < 4; k++) begin
            ix = 8'($random(seed));
            d = $random(seed);
            mem[ix] = d;
            linkOp(1'b1, {1'b0, ix}, d, q);
         end
         foreach (mem[i]) begin
            linkOp(1'b0, 9'(i), 32'h0, q);
            chk("hostRd", q, mem[i]);
         end
         chk("stall", 32'(cpuStall), 32'h1);
         intCnt = 0;
         linkOp(1'b1, 9'h100, 32'h1, q);
         repeat (3) @(posedge clk);
         chk("release", 32'(cpuStall), 32'h0);
         chk("start", cpuStartAddr, 32'h0);
         chk("noLatch", 32'(intCnt), 32'h0);
         cpuRdIdx <= ix;
         repeat (2) @(posedge clk);
         chk("cpuRd", cpuRdData, mem[ix]);
         linkOp(1'b1, 9'h100, 32'h1, q);
         chk("blocked", 32'(intCnt), 32'h0);
         cpuClrHostInt <= 1'b1;
         @(posedge clk);
         cpuClrHostInt <= 1'b0;
         linkOp(1'b1, 9'h100, 32'h1, q);
         chk("hostInt", 32'(intCnt), 32'h1);
         axiWr(boot_seq_pkg::REG_CTRL, 32'h1 | 32'((1 - p) << 4), ok);
         axiWr(boot_seq_pkg::REG_CMD, 32'h1, ok);
         repeat (20) @(posedge clk);
         axiRd(boot_seq_pkg::REG_STATUS, q, r);
         chk("unselBusy", q & 32'h1, 32'h1);
      end
      for (int s = 0; s < 4; s += 3) begin
         doReset(2'(s), 1'b0, 1'b0);
         repeat (2) @(posedge clk);
         chk("noBoot", 32'(cpuStall), 32'h0);
      end
      doReset(boot_seq_pkg::BOOT_NONE, 1'b0, 1'b1);
      linkOp(1'b1, 9'h100, 32'h1, q);
      repeat (4) @(posedge clk);
      chk("sdramWait", 32'(cpuStall), 32'h1);
      sdramInitDone <= 1'b1;
      repeat (4) @(posedge clk);
      chk("sdramDone", 32'(cpuStall), 32'h0);
      romCnt = 0;
      doReset(boot_seq_pkg::BOOT_ROM, 1'b0, 1'b0);
      for (int t = 0; t < 2000 && cpuStall !== 1'b0; t++) @(posedge clk);
      chk("romWords", 32'(romCnt), 32'(boot_seq_pkg::ROM_WORDS));
      for (int i = 0; i < 256; i += 85) begin
         cpuRdIdx <= 8'(i);
         repeat (2) @(posedge clk);
         chk("romCopy", cpuRdData, (boot_seq_pkg::ROM_BASE + 32'(4 * i)) ^ 32'h5A5A_0000);
      end
      axiWr(boot_seq_pkg::REG_CTRL, 32'h1, ok);
      axiWr(boot_seq_pkg::REG_CTRL, 32'h2, ok);
      @(posedge clk);
      chk("pullDown", 32'(link.trstN), 32'h0);
      for (int e = 0; e < 4; e++) begin
         axiWr(boot_seq_pkg::REG_CTRL, 32'(e << 2), ok);
         repeat (2) @(posedge clk);
         chk("emuClr", 32'(emuValid), 32'h0);
         axiWr(boot_seq_pkg::REG_CTRL, 32'(e << 2) | 32'h1, ok);
         repeat (3) @(posedge clk);
         chk("emuValid", 32'(emuValid), 32'h1);
         chk("emuMode", 32'(emuMode), 32'(e != 0));
      end
      end_of_test();
   end
endmodule
